// ===== rtl/bmxc_config.sv
// bus matrix configuration register and policy logic
// assumes synchronous initiator signals on clk, debug mode from the cpu
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bmxc_config
    import bmxc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire bmxc_req_t req,
    output logic [31:0] rdata,
    // cpu state and cache capability
    input wire logic debugMode,
    input wire logic cacheDataEnable,
    // dma flash read miss request from the cache
    input wire logic dmaMissAlloc,
    output logic dmaCacheable,
    output logic dmaAllocate,
    // unmapped accesses per initiator
    input wire logic [NUM_INIT-1:0] unmappedAccess,
    output logic [NUM_INIT-1:0] busError,
    // policy and interrupt
    output bmxc_policy_t policy,
    output logic irq
);
    logic [31:0] config_q, config_d;
    logic [NUM_INIT-1:0] status_q, status_d;
    logic [NUM_INIT-1:0] mask_q, mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic [NUM_INIT-1:0] errGate;

    // error gating per initiator
    always_comb
    begin
        errGate = config_q[BIT_ERR_SHARED:BIT_ERR_FETCH];
        if (debugMode)
        begin
            errGate[INIT_FETCH] = 1'b0;
            errGate[INIT_DATA] = 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INIT; gi++)
        begin : g_err
            assign busError[gi] = unmappedAccess[gi] & errGate[gi];
        end
    endgenerate

    // dma cache policy
    assign dmaCacheable = config_q[BIT_DMA_CACHE] & cacheDataEnable;
    assign dmaAllocate = dmaMissAlloc & dmaCacheable;

    // policy outputs
    assign policy.arbMode = bmxc_arb_t'(config_q[ARB_MSB:ARB_LSB]);
    assign policy.ramWaitState = config_q[BIT_WAIT];
    assign policy.errEnable = errGate;
    assign policy.dmaCacheEnable = config_q[BIT_DMA_CACHE];

    // register writes, sticky status and read data
    always_comb
    begin
        config_d = config_q;
        mask_d = mask_q;
        status_d = status_q;
        rdata_d = 32'h00000000;
        if (req.wr && req.addr == ADDR_CONFIG)
            config_d = req.wdata & CONFIG_WMASK;
        if (req.wr && req.addr == ADDR_IRQ_MASK)
            mask_d = req.wdata[NUM_INIT-1:0];
        if (req.wr && req.addr == ADDR_IRQ_STATUS)
            status_d = status_q & ~req.wdata[NUM_INIT-1:0];
        status_d = status_d | busError;
        if (req.rd)
        begin
            case (req.addr)
                ADDR_CONFIG: rdata_d = config_q;
                ADDR_IRQ_STATUS: rdata_d = {27'h0000000, status_q};
                ADDR_IRQ_MASK: rdata_d = {27'h0000000, mask_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            config_q <= CONFIG_RESET;
            mask_q <= IRQ_MASK_RESET;
            status_q <= '0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            config_q <= config_d;
            mask_q <= mask_d;
            status_q <= status_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign irq = |(status_q & mask_q);

    // assertions
    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        (config_q & ~CONFIG_WMASK) == 32'h00000000)
        else $error("unimplemented config bits not zero");
    a_reset_value: assert property (@(posedge clk)
        $rose(resetn) |-> config_q == CONFIG_RESET)
        else $error("config reset value wrong");
    a_dma_cache_on: assert property (@(posedge clk) disable iff (!resetn)
        dmaCacheable == (config_q[BIT_DMA_CACHE] && cacheDataEnable))
        else $error("dma cacheability wrong");
    a_dma_no_alloc: assert property (@(posedge clk) disable iff (!resetn)
        !config_q[BIT_DMA_CACHE] |-> !dmaAllocate)
        else $error("dma miss allocated while disabled");
    a_shared_err: assert property (@(posedge clk) disable iff (!resetn)
        busError[4] == (unmappedAccess[4] && config_q[BIT_ERR_SHARED]))
        else $error("shared bus error gating wrong");
    a_debug_err: assert property (@(posedge clk) disable iff (!resetn)
        busError[3] == (unmappedAccess[3] && config_q[BIT_ERR_DEBUG]))
        else $error("debug unit error gating wrong");
    a_dma_err: assert property (@(posedge clk) disable iff (!resetn)
        busError[2] == (unmappedAccess[2] && config_q[BIT_ERR_DMA]))
        else $error("dma error gating wrong");
    a_data_err: assert property (@(posedge clk) disable iff (!resetn)
        busError[1] == (unmappedAccess[1] && config_q[BIT_ERR_DATA] && !debugMode))
        else $error("cpu data error gating wrong");
    a_fetch_err: assert property (@(posedge clk) disable iff (!resetn)
        busError[0] == (unmappedAccess[0] && config_q[BIT_ERR_FETCH] && !debugMode))
        else $error("cpu fetch error gating wrong");
    a_wait_write: assert property (@(posedge clk) disable iff (!resetn)
        (req.wr && req.addr == ADDR_CONFIG) |=> policy.ramWaitState == $past(req.wdata[BIT_WAIT]))
        else $error("wait state bit not written");
    a_arb_write: assert property (@(posedge clk) disable iff (!resetn)
        (req.wr && req.addr == ADDR_CONFIG) |=> policy.arbMode == $past(req.wdata[ARB_MSB:ARB_LSB]))
        else $error("arbitration field not written");

    // named steps of register traffic
    sequence s_cfg_write;
        req.wr && req.addr == ADDR_CONFIG;
    endsequence
    sequence s_cfg_read;
        req.rd && req.addr == ADDR_CONFIG;
    endsequence
    sequence s_status_read;
        req.rd && req.addr == ADDR_IRQ_STATUS;
    endsequence
    sequence s_mask_read;
        req.rd && req.addr == ADDR_IRQ_MASK;
    endsequence
    sequence s_mask_write;
        req.wr && req.addr == ADDR_IRQ_MASK;
    endsequence
    sequence s_read_then_idle;
        s_cfg_read ##1 !req.rd;
    endsequence

    property p_cfg_mask;
        @(posedge clk) disable iff (!resetn)
        s_cfg_write |=> config_q == ($past(req.wdata) & CONFIG_WMASK);
    endproperty
    a_cfg_masked_write: assert property (p_cfg_mask)
        else $error("config write not masked");
    property p_cfg_hold;
        @(posedge clk) disable iff (!resetn)
        !(req.wr && req.addr == ADDR_CONFIG) |=> config_q == $past(config_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("config changed without write");
    property p_cfg_read;
        @(posedge clk) disable iff (!resetn)
        s_cfg_read |=> rdata == $past(config_q);
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config read data wrong");
    property p_read_idle;
        @(posedge clk) disable iff (!resetn)
        s_read_then_idle |=> rdata == 32'h00000000;
    endproperty
    a_read_then_idle: assert property (p_read_idle)
        else $error("read data stood too long");
    property p_rdata_quiet;
        @(posedge clk) disable iff (!resetn)
        !req.rd |=> rdata == 32'h00000000;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet)
        else $error("read data without read");
    property p_status_read;
        @(posedge clk) disable iff (!resetn)
        s_status_read |=> rdata == {27'h0000000, $past(status_q)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read data wrong");
    property p_mask_read;
        @(posedge clk) disable iff (!resetn)
        s_mask_read |=> rdata == {27'h0000000, $past(mask_q)};
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask read data wrong");
    property p_mask_write;
        @(posedge clk) disable iff (!resetn)
        s_mask_write |=> mask_q == $past(req.wdata[NUM_INIT-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write lost");
    property p_irq_masked;
        @(posedge clk) disable iff (!resetn)
        (mask_q == '0) |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt with all sources masked");
    property p_irq_raise;
        @(posedge clk) disable iff (!resetn)
        ((busError & mask_q) != '0 && !(req.wr && req.addr == ADDR_IRQ_MASK)) |=> irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("interrupt not raised");
    property p_fetch_debug;
        @(posedge clk) disable iff (!resetn)
        debugMode |-> !busError[INIT_FETCH];
    endproperty
    a_fetch_debug_off: assert property (p_fetch_debug)
        else $error("fetch bus error in debug mode");
    property p_data_debug;
        @(posedge clk) disable iff (!resetn)
        debugMode |-> !busError[INIT_DATA];
    endproperty
    a_data_debug_off: assert property (p_data_debug)
        else $error("data bus error in debug mode");
    property p_dma_needs_cache;
        @(posedge clk) disable iff (!resetn)
        !cacheDataEnable |-> !dmaCacheable;
    endproperty
    a_dma_needs_cache: assert property (p_dma_needs_cache)
        else $error("dma cacheable without data caching");
    property p_dma_alloc_miss;
        @(posedge clk) disable iff (!resetn)
        dmaAllocate |-> dmaMissAlloc;
    endproperty
    a_dma_alloc_miss: assert property (p_dma_alloc_miss)
        else $error("dma allocation without miss");
    property p_dma_cache_write;
        @(posedge clk) disable iff (!resetn)
        s_cfg_write |=> policy.dmaCacheEnable == $past(req.wdata[BIT_DMA_CACHE]);
    endproperty
    a_dma_cache_write: assert property (p_dma_cache_write)
        else $error("dma cache bit not written");
    property p_err_write;
        @(posedge clk) disable iff (!resetn)
        s_cfg_write |=> config_q[BIT_ERR_SHARED:BIT_ERR_FETCH]
            == $past(req.wdata[BIT_ERR_SHARED:BIT_ERR_FETCH]);
    endproperty
    a_err_write: assert property (p_err_write)
        else $error("error enables not written");
    property p_reset_state;
        @(posedge clk)
        $rose(resetn) |-> status_q == '0 && mask_q == '0 && rdata == 32'h00000000;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("status, mask or read data not cleared by reset");
    property p_reset_arb;
        @(posedge clk)
        $rose(resetn) |-> policy.arbMode == ARB_MODE1;
    endproperty
    a_reset_arb: assert property (p_reset_arb)
        else $error("arbitration mode after reset wrong");
    property p_err_policy;
        @(posedge clk) disable iff (!resetn)
        !debugMode |-> policy.errEnable == config_q[BIT_ERR_SHARED:BIT_ERR_FETCH];
    endproperty
    a_err_policy: assert property (p_err_policy)
        else $error("error enable policy wrong");
    property p_wait_hold;
        @(posedge clk) disable iff (!resetn)
        !(req.wr && req.addr == ADDR_CONFIG) |=> $stable(policy.ramWaitState);
    endproperty
    a_wait_hold: assert property (p_wait_hold)
        else $error("wait state changed without write");
    property p_shared_off;
        @(posedge clk) disable iff (!resetn)
        !config_q[BIT_ERR_SHARED] |-> !busError[INIT_SHARED];
    endproperty
    a_shared_off: assert property (p_shared_off)
        else $error("shared bus error while disabled");
    property p_debug_off;
        @(posedge clk) disable iff (!resetn)
        !config_q[BIT_ERR_DEBUG] |-> !busError[INIT_DEBUG];
    endproperty
    a_debug_off: assert property (p_debug_off)
        else $error("debug unit error while disabled");
    property p_dma_off;
        @(posedge clk) disable iff (!resetn)
        !config_q[BIT_ERR_DMA] |-> !busError[INIT_DMA];
    endproperty
    a_dma_off: assert property (p_dma_off)
        else $error("dma error while disabled");

    // sticky status per initiator, set wins over clear
    generate
        for (gi = 0; gi < NUM_INIT; gi++)
        begin : g_status_chk
            a_status_set: assert property (@(posedge clk) disable iff (!resetn)
                busError[gi] |=> status_q[gi])
                else $error("status bit not set by bus error");
            a_status_clear: assert property (@(posedge clk) disable iff (!resetn)
                (req.wr && req.addr == ADDR_IRQ_STATUS && req.wdata[gi] && !busError[gi])
                |=> !status_q[gi])
                else $error("status bit not cleared");
        end
    endgenerate
endmodule // bmxc_config
`default_nettype wire

// ===== rtl/bmxc_pkg.sv
// bus matrix configuration package: register offsets, fields, reset values
// assumes a single system clock domain
package bmxc_pkg;
    // register offsets (byte addresses)
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
    // configuration field positions
    localparam int BIT_DMA_CACHE = 26;
    localparam int BIT_ERR_SHARED = 20;
    localparam int BIT_ERR_DEBUG = 19;
    localparam int BIT_ERR_DMA = 18;
    localparam int BIT_ERR_DATA = 17;
    localparam int BIT_ERR_FETCH = 16;
    localparam int BIT_WAIT = 6;
    localparam int ARB_MSB = 2;
    localparam int ARB_LSB = 0;
    localparam int NUM_INIT = 5;
    // writable bits and reset value of the configuration register
    localparam logic [31:0] CONFIG_WMASK = 32'h041f0047;
    localparam logic [31:0] CONFIG_RESET = 32'h041f0041;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    // initiator index: 0 fetch, 1 data, 2 dma, 3 debug, 4 shared bus
    localparam int INIT_FETCH = 0;
    localparam int INIT_DATA = 1;
    localparam int INIT_DMA = 2;
    localparam int INIT_DEBUG = 3;
    localparam int INIT_SHARED = 4;
    // arbitration modes
    typedef enum logic [2:0] {
        ARB_MODE0 = 3'h0,
        ARB_MODE1 = 3'h1,
        ARB_MODE2 = 3'h2
    } bmxc_arb_t;
    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bmxc_req_t;
    // decoded policy outputs
    typedef struct packed {
        bmxc_arb_t arbMode;
        logic ramWaitState;
        logic [NUM_INIT-1:0] errEnable;
        logic dmaCacheEnable;
    } bmxc_policy_t;
endpackage

// ===== tb/bmxc_initiators.sv
// initiator model: random unmapped accesses, debug mode, cache state
// assumes the design samples these on the rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module bmxc_initiators
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // initiator side
    output logic debugMode,
    output logic cacheDataEnable,
    output logic dmaMissAlloc,
    output logic [4:0] unmappedAccess
);
    int seed = 40999;
    always @(posedge clk)
    begin
        {debugMode, cacheDataEnable, dmaMissAlloc, unmappedAccess} <=
            resetn ? 8'($random(seed)) : 8'h00;
    end
endmodule // bmxc_initiators
`default_nettype wire

// ===== tb/bmxc_config_tb.sv
// testbench: register traffic, error gating, cache policy, interrupt
// assumes the initiator model drives the far side
`timescale 1ns/1ps
`default_nettype none
module bmxc_config_tb import bmxc_pkg::*;;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    bmxc_req_t req = '0;
    logic [31:0] rdata, cfg_q, rExp_q;
    logic [4:0] busError, unmappedAccess, st_q, msk_q;
    logic debugMode, cacheDataEnable, dmaMissAlloc, dmaCacheable, dmaAllocate, irq, rdPend_q;
    bmxc_policy_t policy;
    int fails = 0;
    int cmp_count = 0;
    int seed = 40999;
    always #4 clk = ~clk;
    bmxc_config dut_u (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
        .debugMode(debugMode), .cacheDataEnable(cacheDataEnable), .dmaMissAlloc(dmaMissAlloc),
        .dmaCacheable(dmaCacheable), .dmaAllocate(dmaAllocate), .unmappedAccess(unmappedAccess),
        .busError(busError), .policy(policy), .irq(irq));
    bmxc_initiators far_u (.clk(clk), .resetn(resetn), .debugMode(debugMode),
        .cacheDataEnable(cacheDataEnable), .dmaMissAlloc(dmaMissAlloc),
        .unmappedAccess(unmappedAccess));
    function automatic logic [4:0] errEn(input logic [31:0] c, input logic dbg);
        errEn = c[20:16] & ~{3'h0, dbg, dbg};
    endfunction
    task automatic bad(input string m);
        fails++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic op(input logic [3:0] a, input logic [31:0] d, input logic w, input logic r);
        @(posedge clk);
        req <= '{a, d, w, r};
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // reference register model
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q <= CONFIG_RESET;
            st_q <= 5'h00;
            msk_q <= IRQ_MASK_RESET;
            rdPend_q <= 1'b0;
            rExp_q <= 32'h0;
        end
        else
        begin
            if (req.wr && req.addr == ADDR_CONFIG)
                cfg_q <= req.wdata & CONFIG_WMASK;
            if (req.wr && req.addr == ADDR_IRQ_MASK)
                msk_q <= req.wdata[4:0];
            st_q <= (st_q & ~((req.wr && req.addr == ADDR_IRQ_STATUS) ? req.wdata[4:0] : 5'h00))
                | (unmappedAccess & errEn(cfg_q, debugMode));
            rdPend_q <= req.rd;
            rExp_q <= req.addr == ADDR_CONFIG ? cfg_q : req.addr == ADDR_IRQ_STATUS ?
                {27'h0, st_q} : req.addr == ADDR_IRQ_MASK ? {27'h0, msk_q} : 32'h0;
        end
    end
    always @(negedge clk)
    begin
        if (resetn)
        begin
            cmp_count += 5;
            if (busError !==
                (unmappedAccess & errEn(cfg_q, debugMode)))
                bad("bus error gating");
            if ({dmaCacheable, dmaAllocate} !==
                ({2{cfg_q[26] & cacheDataEnable}} & {1'b1, dmaMissAlloc}))
                bad("dma cacheability");
            if (policy !== {cfg_q[2:0], cfg_q[6], errEn(cfg_q, debugMode), cfg_q[26]})
                bad("policy outputs");
            if (irq !== |(st_q & msk_q))
                bad("interrupt level");
            if (rdata !== (rdPend_q ? rExp_q : 32'h0))
                bad("read data");
        end
    end
    initial
    begin
        logic [31:0] r;
        logic [31:0] d;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        op(ADDR_CONFIG, 32'h0, 1'b0, 1'b1);
        op(ADDR_CONFIG, 32'hfffffffa, 1'b1, 1'b0);
        op(ADDR_CONFIG, 32'h0, 1'b0, 1'b1);
        for (int k = 0; k < 3; k++)
        begin
            op(ADDR_CONFIG, 32'(k), 1'b1, 1'b0);
            op(ADDR_CONFIG, 32'h0, 1'b0, 1'b1);
        end
        $display("directed register test done");
        op(ADDR_IRQ_MASK, 32'h1f, 1'b1, 1'b0);
        for (int n = 0; n < 3000; n++)
        begin
            r = $random(seed);
            d = $random(seed);
            d[2:0] = {1'b0, r[5], r[4] & ~r[5]};
            op({r[3:2], 2'h0}, d, r[7:6] == 2'h1, r[7:6] == 2'h2);
        end
        op(ADDR_IRQ_STATUS, 32'h1f, 1'b1, 1'b0);
        op(ADDR_IRQ_STATUS, 32'h0, 1'b0, 1'b1);
        op(ADDR_CONFIG, 32'h0, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        $display("random traffic test done");
        results();
    end
endmodule // bmxc_config_tb
`default_nettype wire
